// *** core/mcsd_defs.svh ***
// Constants for the microcode sequencer and decode block
`ifndef MCSD_DEFS_SVH
`define MCSD_DEFS_SVH

// Timing figures in nanoseconds and the cycle counts derived from them
`define MCSD_CLK_PERIOD_NS 100
`define MCSD_STROBE_PERIOD_NS 200
`define MCSD_STROBE_PULSE_NS 50
`define MCSD_EXEC_CYCLES (`MCSD_STROBE_PERIOD_NS / `MCSD_CLK_PERIOD_NS)
`define MCSD_PULSE_CYCLES ((`MCSD_STROBE_PULSE_NS + `MCSD_CLK_PERIOD_NS - 1) / `MCSD_CLK_PERIOD_NS)

// Wait counter preset on a taken branch
`define MCSD_WAIT_PRESET 256

// Register byte addresses
`define MCSD_REG_CTRL 12'h000
`define MCSD_REG_STATUS 12'h004
`define MCSD_REG_IOFF 12'h008

// Control register fields and reset value
`define MCSD_CTRL_RUN 0
`define MCSD_CTRL_DDW 1
`define MCSD_CTRL_RESTART 2
`define MCSD_CTRL_MASK 32'h0000_0003
`define MCSD_CTRL_RESET 32'h0000_0001

// Instruction fields
`define MCSD_IR_ALU 15
`define MCSD_IR_POL 8
`define MCSD_IR_C0 8
`define MCSD_IR_C1 7
`define MCSD_IR_WAIT 4
`define MCSD_IR_RET 11

// I/O function numbers with a fixed meaning inside the block
`define MCSD_IOF_WRITE_GATE 1
`define MCSD_IOF_DRV_BUS 2
`define MCSD_IOF_BUF_DATA 3
`define MCSD_IOF_BUF_WRITE 4
`define MCSD_IOF_BUF_WE_N 5

// Branch condition codes driven from inside the block
`define MCSD_COND_WRITE_DATA 5
`define MCSD_COND_WRITE_BUSY 6

`endif

// *** core/mcsd_pkg.sv ***
// Types shared by the microcode sequencer and decode block
package mcsd_pkg;

  // Instruction classes decoded from the top bits
  typedef enum logic [2:0] {
    OP_JUMP = 3'b000,
    OP_CALL = 3'b001,
    OP_IO = 3'b011,
    OP_BRANCH = 3'b010,
    OP_ALU = 3'b110
  } mcsd_op_type;

  // Control code applied to an addressed I/O flip-flop
  typedef enum logic [1:0] {
    CTL_TOGGLE = 2'b00,
    CTL_SET = 2'b01,
    CTL_CLEAR = 2'b10,
    CTL_NOP = 2'b11
  } mcsd_ctl_type;

  // APB request and answer carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } mcsd_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } mcsd_apb_rsp_type;

endpackage : mcsd_pkg

// *** core/mcsd_wait_counter.sv ***
// Wait counter that holds the sequencer until it reaches its limit
`timescale 1ns/1ns
`include "mcsd_defs.svh"
module mcsd_wait_counter #(
  parameter int LIMIT = `MCSD_WAIT_PRESET
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic step,
  input wire logic preset,
  output logic expired
);
  import mcsd_pkg::*;

  localparam int CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LIMIT_C = CW'(LIMIT);

  typedef struct packed {
    logic [CW-1:0] count;
  } mcsd_wait_state_type;

  mcsd_wait_state_type s_reg;
  mcsd_wait_state_type s_next;

  // Refuse a limit that cannot be counted
  initial begin
    if (LIMIT < 1) begin
      $error("wait limit must be at least one");
    end
  end

  // Start clears, preset jumps to the limit, step counts up to it
  always_comb begin
    s_next = s_reg;
    if (start) begin
      s_next.count = '0;
    end else if (preset) begin
      s_next.count = LIMIT_C;
    end else if (step && s_reg.count != LIMIT_C) begin
      s_next.count = s_reg.count + CW'(1);
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign expired = (s_reg.count == LIMIT_C);

endmodule : mcsd_wait_counter

// *** core/mcsd_top.sv ***
// Microinstruction decode, next-address sequencing, I/O strobes and sector buffer
`timescale 1ns/1ns
`include "mcsd_defs.svh"
module mcsd_top #(
  parameter int BUF_DEPTH = 2048,
  parameter int RET_DEPTH = 4
) (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire mcsd_pkg::mcsd_apb_req_type APB_REQ,
  output mcsd_pkg::mcsd_apb_rsp_type APB_RSP,
  output logic [10:0] ROM_ADDR,
  input wire logic [15:0] ROM_DATA,
  output logic [15:0] MICRO_INSTR,
  output logic ALU_OP_STROBE,
  input wire logic [31:0] COND_IN,
  input wire logic WRITE_IN_PROGRESS_N,
  input wire logic SERIAL_IN,
  output logic [15:0] IO_STROBE_N,
  output logic [15:0] DRIVE_OUT,
  output logic [15:0] HOST_OUT,
  output logic DRIVE_WRITE_GATE,
  output logic BRANCH_TAKEN_N,
  output logic SEQUENCER_ADVANCE,
  output logic BUFFER_SERIAL_OUT,
  output logic DD_ADDR_OR_BIT0,
  output logic DD_ADDR_OR_BIT1
);
  import mcsd_pkg::*;

  localparam int EXEC = `MCSD_EXEC_CYCLES;
  localparam int PULSE = `MCSD_PULSE_CYCLES;
  localparam int PW = (EXEC > 2) ? $clog2(EXEC) : 1;
  localparam int BAW = $clog2(BUF_DEPTH);
  localparam int RPW = $clog2(RET_DEPTH + 1);
  localparam logic [PW-1:0] PHASE_LAST = PW'(EXEC - 1);
  localparam logic [PW:0] PULSE_C = (PW + 1)'(PULSE);
  localparam logic [RPW-1:0] RET_FULL = RPW'(RET_DEPTH);

  typedef struct packed {
    logic [31:0] cond_s1;
    logic [31:0] cond_s2;
    logic wip_s1;
    logic wip_s2;
    logic ser_s1;
    logic ser_s2;
    logic [PW-1:0] phase;
    logic [15:0] ir;
    logic [10:0] cur_addr;
    logic [10:0] rom_addr;
    logic [RET_DEPTH-1:0][10:0] ret_file;
    logic [RPW-1:0] ret_ptr;
    logic wait_armed;
    logic [15:0] io_ff;
    logic [15:0] strobe_n;
    logic [15:0] drive_out;
    logic [15:0] host_out;
    logic write_gate;
    logic branch_taken_n;
    logic advance;
    logic alu_op;
    logic dd_or0;
    logic dd_or1;
    logic data_in;
    logic serial_out;
    logic prev_out;
    logic [BUF_DEPTH-1:0] buf_mem;
    logic [BAW-1:0] buf_addr;
    logic [31:0] ctrl;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } mcsd_state_type;

  mcsd_state_type s_reg;
  mcsd_state_type s_next;
  mcsd_op_type op_class;
  logic [31:0] cond_vec;
  logic cond_true;
  logic branch_decode;
  logic taken;
  logic dd_case;
  logic exec;
  logic wait_start;
  logic wait_step;
  logic wait_preset;
  logic wait_expired;
  logic [10:0] pc_plus;
  logic [10:0] next_addr;
  logic [15:0] io_pulse;
  logic [3:0] io_func;
  mcsd_ctl_type ctl;
  logic apb_setup;
  logic apb_access;
  logic apb_mapped;
  logic restart;
  logic [31:0] read_val;

  // Refuse sizes the logic cannot serve
  initial begin
    if (EXEC < 2 || PULSE >= EXEC) begin
      $error("strobe timing does not fit the clock");
    end
    if (BUF_DEPTH < 2 || BUF_DEPTH != (1 << BAW) || RET_DEPTH < 1) begin
      $error("buffer depth must be a power of two and return file non-empty");
    end
  end

  // Wait/hold counter
  mcsd_wait_counter #(
    .LIMIT(`MCSD_WAIT_PRESET)
  ) u_wait (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .start(wait_start),
    .step(wait_step),
    .preset(wait_preset),
    .expired(wait_expired)
  );

  // Instruction class, condition selection and branch outcome
  always_comb begin
    if (s_reg.ir[`MCSD_IR_ALU]) begin
      op_class = OP_ALU;
    end else if (s_reg.ir[14]) begin
      op_class = OP_BRANCH;
    end else if (s_reg.ir[13]) begin
      op_class = OP_IO;
    end else if (s_reg.ir[12]) begin
      op_class = OP_CALL;
    end else begin
      op_class = OP_JUMP;
    end
    cond_vec = s_reg.cond_s2;
    cond_vec[`MCSD_COND_WRITE_DATA] = s_reg.data_in;
    cond_vec[`MCSD_COND_WRITE_BUSY] = !s_reg.wip_s2;
    if (s_reg.ir[13]) begin
      cond_true = cond_vec[{1'b1, s_reg.ir[12:9]}];
    end else begin
      cond_true = cond_vec[{1'b0, s_reg.ir[12:9]}];
    end
    branch_decode = (op_class == OP_BRANCH);
    taken = branch_decode && (cond_true == s_reg.ir[`MCSD_IR_POL]);
    dd_case = branch_decode && s_reg.ctrl[`MCSD_CTRL_DDW] && (s_reg.ir[13:10] == 4'hF) && !taken;
    io_func = s_reg.ir[12:9];
    ctl = mcsd_ctl_type'(s_reg.ir[8:7]);
    pc_plus = s_reg.cur_addr + 11'h001;
  end

  // APB decode and read multiplexer
  always_comb begin
    apb_setup = APB_REQ.psel && !APB_REQ.penable;
    apb_access = APB_REQ.psel && APB_REQ.penable && s_reg.pready;
    apb_mapped = (APB_REQ.paddr == `MCSD_REG_CTRL) || (APB_REQ.paddr == `MCSD_REG_STATUS) ||
                 (APB_REQ.paddr == `MCSD_REG_IOFF);
    restart = apb_access && APB_REQ.pwrite && !s_reg.pslverr && (APB_REQ.paddr == `MCSD_REG_CTRL) &&
              APB_REQ.pwdata[`MCSD_CTRL_RESTART];
    unique case (APB_REQ.paddr)
      `MCSD_REG_CTRL: read_val = s_reg.ctrl;
      `MCSD_REG_STATUS: read_val = {s_reg.ir, 2'b00, s_reg.wait_armed, s_reg.advance,
                                    ~s_reg.branch_taken_n, s_reg.cur_addr};
      `MCSD_REG_IOFF: read_val = {16'(s_reg.buf_addr), s_reg.io_ff};
      default: read_val = 32'h0000_0000;
    endcase
  end

  // Next-address selection, wait control and return file
  always_comb begin
    exec = s_reg.ctrl[`MCSD_CTRL_RUN] && (s_reg.phase == PHASE_LAST);
    next_addr = s_reg.cur_addr;
    wait_start = 1'b0;
    wait_step = 1'b0;
    wait_preset = 1'b0;
    unique case (op_class)
      OP_ALU: next_addr = pc_plus;
      OP_IO: begin
        next_addr = pc_plus;
        wait_start = exec && s_reg.ir[`MCSD_IR_WAIT];
      end
      OP_JUMP: begin
        if (s_reg.ir[`MCSD_IR_RET] && s_reg.ret_ptr != '0) begin
          next_addr = s_reg.ret_file[s_reg.ret_ptr - RPW'(1)];
        end else begin
          next_addr = s_reg.ir[10:0];
        end
      end
      OP_CALL: next_addr = s_reg.ir[10:0];
      OP_BRANCH: begin
        if (dd_case) begin
          next_addr = {s_reg.cur_addr[10:8], s_reg.ir[7:2], s_reg.ir[1:0] | {s_reg.prev_out, s_reg.serial_out}};
        end else if (taken) begin
          next_addr = {s_reg.cur_addr[10:8], s_reg.ir[7:0]};
          wait_preset = exec && s_reg.wait_armed;
        end else if (s_reg.wait_armed && !wait_expired) begin
          next_addr = s_reg.cur_addr;
          wait_step = exec;
        end else begin
          next_addr = pc_plus;
        end
      end
    endcase
  end

  // One strobe per I/O instruction, only in the execute slot
  always_comb begin
    io_pulse = 16'h0000;
    if (exec && op_class == OP_IO) begin
      io_pulse[io_func] = 1'b1;
    end
  end

  // Whole next state of the block
  always_comb begin
    s_next = s_reg;
    s_next.cond_s1 = COND_IN;
    s_next.cond_s2 = s_reg.cond_s1;
    s_next.wip_s1 = WRITE_IN_PROGRESS_N;
    s_next.wip_s2 = s_reg.wip_s1;
    s_next.ser_s1 = SERIAL_IN;
    s_next.ser_s2 = s_reg.ser_s1;
    s_next.alu_op = 1'b0;
    s_next.dd_or0 = 1'b0;
    s_next.dd_or1 = 1'b0;
    // Phase counter; the instruction is fetched in phase zero
    if (!s_reg.ctrl[`MCSD_CTRL_RUN] || exec) begin
      s_next.phase = '0;
    end else begin
      s_next.phase = s_reg.phase + PW'(1);
    end
    if (s_reg.ctrl[`MCSD_CTRL_RUN] && s_reg.phase == '0) begin
      s_next.ir = ROM_DATA;
      s_next.cur_addr = s_reg.rom_addr;
    end
    if (exec) begin
      s_next.rom_addr = next_addr;
      s_next.advance = (op_class != OP_BRANCH) || taken || dd_case || !s_reg.wait_armed || wait_expired;
      s_next.branch_taken_n = !taken;
      s_next.alu_op = (op_class == OP_ALU);
      if (op_class == OP_IO && s_reg.ir[`MCSD_IR_WAIT]) begin
        s_next.wait_armed = 1'b1;
      end else if (op_class == OP_BRANCH && s_next.advance) begin
        s_next.wait_armed = 1'b0;
      end
      if (dd_case) begin
        s_next.dd_or0 = s_reg.serial_out;
        s_next.dd_or1 = s_reg.prev_out;
      end
      if (op_class == OP_CALL) begin
        if (s_reg.ret_ptr == RET_FULL) begin
          s_next.ret_file[RET_DEPTH - 1] = pc_plus;
        end else begin
          s_next.ret_file[s_reg.ret_ptr] = pc_plus;
          s_next.ret_ptr = s_reg.ret_ptr + RPW'(1);
        end
      end else if (op_class == OP_JUMP && s_reg.ir[`MCSD_IR_RET] && s_reg.ret_ptr != '0) begin
        s_next.ret_ptr = s_reg.ret_ptr - RPW'(1);
      end
    end
    // I/O flip-flops take the control code on their strobe
    for (int i = 0; i < 16; i++) begin
      if (io_pulse[i]) begin
        unique case (ctl)
          CTL_TOGGLE: s_next.io_ff[i] = !s_reg.io_ff[i];
          CTL_SET: s_next.io_ff[i] = 1'b1;
          CTL_CLEAR: s_next.io_ff[i] = 1'b0;
          CTL_NOP: s_next.io_ff[i] = s_reg.io_ff[i];
        endcase
      end
    end
    // Serial input bit is caught on the buffer bit clock
    if (io_pulse[`MCSD_IOF_BUF_DATA]) begin
      s_next.data_in = s_reg.ser_s2;
    end
    // Buffer write clock stores or drains one bit
    if (io_pulse[`MCSD_IOF_BUF_WRITE]) begin
      if (!s_reg.io_ff[`MCSD_IOF_BUF_WE_N] && s_reg.ir[`MCSD_IR_C1]) begin
        s_next.buf_mem[s_reg.buf_addr] = s_reg.data_in;
        s_next.buf_addr = s_reg.buf_addr + BAW'(1);
      end else if (s_reg.io_ff[`MCSD_IOF_BUF_WE_N] && s_reg.ir[`MCSD_IR_C0]) begin
        s_next.serial_out = s_reg.buf_mem[s_reg.buf_addr];
        s_next.prev_out = s_reg.serial_out;
        s_next.buf_addr = s_reg.buf_addr + BAW'(1);
      end
    end
    // Strobe stands for the pulse width at the start of the next period
    s_next.strobe_n = ~((s_next.phase < PULSE_C[PW-1:0]) ? io_pulse : 16'h0000);
    if (!exec) begin
      s_next.strobe_n = 16'hFFFF;
    end
    // Route flip-flops to drive or host side
    s_next.drive_out = s_next.io_ff & {16{s_next.io_ff[`MCSD_IOF_DRV_BUS]}};
    s_next.host_out = s_next.io_ff & {16{!s_next.io_ff[`MCSD_IOF_DRV_BUS]}};
    s_next.write_gate = s_next.io_ff[`MCSD_IOF_WRITE_GATE] && s_next.io_ff[`MCSD_IOF_DRV_BUS];
    // Software restart returns the sequencer to address zero
    if (restart) begin
      s_next.rom_addr = 11'h000;
      s_next.cur_addr = 11'h000;
      s_next.phase = '0;
      s_next.ret_ptr = '0;
      s_next.wait_armed = 1'b0;
      s_next.advance = 1'b1;
      s_next.branch_taken_n = 1'b1;
    end
    // APB slave: zero wait states, error on unmapped address
    s_next.pready = apb_setup;
    s_next.pslverr = apb_setup && !apb_mapped;
    s_next.prdata = (apb_setup && !APB_REQ.pwrite) ? read_val : 32'h0000_0000;
    if (apb_access && APB_REQ.pwrite && !s_reg.pslverr && APB_REQ.paddr == `MCSD_REG_CTRL) begin
      s_next.ctrl = APB_REQ.pwdata & `MCSD_CTRL_MASK;
    end
  end

  // State register; reset clears the counter to address zero
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      s_reg <= '0;
      s_reg.ctrl <= `MCSD_CTRL_RESET;
      s_reg.strobe_n <= 16'hFFFF;
      s_reg.branch_taken_n <= 1'b1;
      s_reg.advance <= 1'b1;
      s_reg.wip_s1 <= 1'b1;
      s_reg.wip_s2 <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign APB_RSP = '{prdata: s_reg.prdata, pready: s_reg.pready, pslverr: s_reg.pslverr};
  assign ROM_ADDR = s_reg.rom_addr;
  assign MICRO_INSTR = s_reg.ir;
  assign ALU_OP_STROBE = s_reg.alu_op;
  assign IO_STROBE_N = s_reg.strobe_n;
  assign DRIVE_OUT = s_reg.drive_out;
  assign HOST_OUT = s_reg.host_out;
  assign DRIVE_WRITE_GATE = s_reg.write_gate;
  assign BRANCH_TAKEN_N = s_reg.branch_taken_n;
  assign SEQUENCER_ADVANCE = s_reg.advance;
  assign BUFFER_SERIAL_OUT = s_reg.serial_out;
  assign DD_ADDR_OR_BIT0 = s_reg.dd_or0;
  assign DD_ADDR_OR_BIT1 = s_reg.dd_or1;

endmodule : mcsd_top

// *** verification/mcsd_rom_model.sv ***
// Microprogram store model feeding the instruction register
`timescale 1ns/1ns
module mcsd_rom_model (
  input wire logic [10:0] rom_addr,
  output logic [15:0] rom_data
);
  logic [15:0] mem [0:2047];
  // Combinational read, valid in the fetch cycle after the address moves
  assign rom_data = mem[rom_addr];
endmodule : mcsd_rom_model

// *** verification/mcsd_assertions.sv ***
// Concurrent checks on the sequencer and decode ports
`timescale 1ns/1ns
module mcsd_checker (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire mcsd_pkg::mcsd_apb_req_type APB_REQ,
  input wire mcsd_pkg::mcsd_apb_rsp_type APB_RSP,
  input wire logic [10:0] ROM_ADDR,
  input wire logic [15:0] MICRO_INSTR,
  input wire logic ALU_OP_STROBE,
  input wire logic [15:0] IO_STROBE_N,
  input wire logic [15:0] DRIVE_OUT,
  input wire logic [15:0] HOST_OUT,
  input wire logic DRIVE_WRITE_GATE,
  input wire logic BRANCH_TAKEN_N,
  input wire logic SEQUENCER_ADVANCE
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  // Step sequences of a strobe and of a taken branch
  sequence s_strobe;
    IO_STROBE_N != 16'hFFFF;
  endsequence
  sequence s_taken;
    $fell(BRANCH_TAKEN_N);
  endsequence
  property p_one_strobe;
    $onehot0(~IO_STROBE_N);
  endproperty
  property p_strobe_pulse;
    s_strobe |=> IO_STROBE_N == 16'hFFFF;
  endproperty
  property p_strobe_cause;
    s_strobe |-> MICRO_INSTR[15:13] == 3'b001 && !IO_STROBE_N[MICRO_INSTR[12:9]];
  endproperty
  property p_gate;
    DRIVE_WRITE_GATE == (DRIVE_OUT[1] && DRIVE_OUT[2]);
  endproperty
  property p_bus_split;
    (DRIVE_OUT == 16'h0000 || HOST_OUT == 16'h0000) && !HOST_OUT[2];
  endproperty
  property p_alu;
    ALU_OP_STROBE |-> MICRO_INSTR[15] ##1 !ALU_OP_STROBE;
  endproperty
  property p_taken_target;
    s_taken |-> MICRO_INSTR[15:14] == 2'b01 && ROM_ADDR[7:0] == MICRO_INSTR[7:0];
  endproperty
  property p_taken_len;
    s_taken |=> !BRANCH_TAKEN_N ##1 (BRANCH_TAKEN_N || MICRO_INSTR[15:14] == 2'b01);
  endproperty
  property p_hold;
    !SEQUENCER_ADVANCE && !$past(SEQUENCER_ADVANCE) |-> $stable(ROM_ADDR);
  endproperty
  property p_reset;
    disable iff (1'b0) !RESETN |=> ROM_ADDR == 11'h000 && IO_STROBE_N == 16'hFFFF && BRANCH_TAKEN_N;
  endproperty
  property p_apb_ready;
    APB_REQ.psel && !APB_REQ.penable |=> APB_RSP.pready;
  endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("more than one strobe low");
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe longer than a cycle");
  a_strobe_cause: assert property (p_strobe_cause) else $error("strobe bit not the coded function");
  a_gate: assert property (p_gate) else $error("write gate not flop1 and select");
  a_bus_split: assert property (p_bus_split) else $error("flops on both buses");
  a_alu: assert property (p_alu) else $error("bad arithmetic strobe");
  a_taken_target: assert property (p_taken_target) else $error("bad branch target");
  a_taken_len: assert property (p_taken_len) else $error("taken flag not one period");
  a_hold: assert property (p_hold) else $error("address moved while held");
  a_reset: assert property (p_reset) else $error("bad reset state");
  a_apb_ready: assert property (p_apb_ready) else $error("no ready after setup");
endmodule : mcsd_checker

bind mcsd_top mcsd_checker i_chk (
  .CORE_CLK(CORE_CLK), .RESETN(RESETN), .APB_REQ(APB_REQ), .APB_RSP(APB_RSP), .ROM_ADDR(ROM_ADDR),
  .MICRO_INSTR(MICRO_INSTR), .ALU_OP_STROBE(ALU_OP_STROBE), .IO_STROBE_N(IO_STROBE_N),
  .DRIVE_OUT(DRIVE_OUT), .HOST_OUT(HOST_OUT), .DRIVE_WRITE_GATE(DRIVE_WRITE_GATE),
  .BRANCH_TAKEN_N(BRANCH_TAKEN_N), .SEQUENCER_ADVANCE(SEQUENCER_ADVANCE)
);

// *** verification/microcode_sequencer_decode_tb_top.sv ***
// Testbench running two short microprograms and register accesses
`timescale 1ns/1ns
`include "mcsd_defs.svh"
module microcode_sequencer_decode_tb_top;
  import mcsd_pkg::*;
  logic core_clk, resetn, ser_out, or0, or1, alu_stb, gate, taken_n, adv, er, wip_n, ser_in;
  mcsd_apb_req_type req;
  mcsd_apb_rsp_type rsp;
  logic [10:0] rom_addr, last_addr;
  logic [15:0] rom_data, instr, strobe_n, drv_out, host_out;
  logic [31:0] rd, cond_in;
  int err_total, n_checks, held, alu_cnt, taken_cnt, gate_hi, k, or_cnt;
  int stb_cnt [16];
  logic [10:0] seen [$];
  logic [10:0] path [11] = '{11'h001, 11'h002, 11'h010, 11'h030, 11'h040, 11'h041, 11'h031, 11'h032,
    11'h033, 11'h034, 11'h035};

  mcsd_rom_model i_rom (.rom_addr(rom_addr), .rom_data(rom_data));
  // Two-bit sector buffer so that two stored bits wrap round and drain back
  mcsd_top #(.BUF_DEPTH(2)) i_dut (.CORE_CLK(core_clk), .RESETN(resetn), .APB_REQ(req), .APB_RSP(rsp),
    .ROM_ADDR(rom_addr), .ROM_DATA(rom_data), .MICRO_INSTR(instr), .ALU_OP_STROBE(alu_stb), .COND_IN(cond_in),
    .WRITE_IN_PROGRESS_N(wip_n), .SERIAL_IN(ser_in), .IO_STROBE_N(strobe_n), .DRIVE_OUT(drv_out),
    .HOST_OUT(host_out), .DRIVE_WRITE_GATE(gate), .BRANCH_TAKEN_N(taken_n), .SEQUENCER_ADVANCE(adv),
    .BUFFER_SERIAL_OUT(ser_out), .DD_ADDR_OR_BIT0(or0), .DD_ADDR_OR_BIT1(or1));

  // Free running 10 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Records address changes, counts cycles of advance low and of both OR bits high, and active cycles of the strobe, ALU, taken and gate outputs
  always @(posedge core_clk) begin
    if (resetn) begin
      if (rom_addr !== last_addr) seen.push_back(rom_addr);
      last_addr = rom_addr;
      for (int i = 0; i < 16; i++) if (strobe_n[i] === 1'b0) stb_cnt[i]++;
      if (adv === 1'b0) held++;
      if (alu_stb === 1'b1) alu_cnt++;
      if (taken_n === 1'b0) taken_cnt++;
      if (gate === 1'b1) gate_hi++;
      if (or0 === 1'b1 && or1 === 1'b1) or_cnt++;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask : chk

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  // One APB transfer: setup, then access held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge core_clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) chk("pready", 1, 0);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
  endtask : apb

  // Main sequence
  initial begin
    req = '0;
    wip_n = 1'b1;
    ser_in = 1'b1;
    cond_in = 32'h0001_0000;
    resetn = 1'b0;
    last_addr = 11'h000;
    for (int i = 0; i < 2048; i++) i_rom.mem[i] = 16'h0000;
    i_rom.mem[11'h000] = 16'h2480; // Set drive bus select
    i_rom.mem[11'h001] = 16'h2280; // Set write gate flop
    i_rom.mem[11'h002] = 16'h0010; // Jump
    i_rom.mem[11'h010] = 16'h4C30; // Branch taken on write busy low
    i_rom.mem[11'h030] = 16'h1040; // Call
    i_rom.mem[11'h040] = 16'h8000; // Arithmetic
    i_rom.mem[11'h041] = 16'h0800; // Return
    i_rom.mem[11'h031] = 16'h2200; // Toggle write gate flop
    i_rom.mem[11'h032] = 16'h4D30; // Branch untaken
    i_rom.mem[11'h033] = 16'h2190; // No-op with wait armed
    i_rom.mem[11'h034] = 16'h4D30; // Untaken branch held by the wait
    i_rom.mem[11'h035] = 16'h0035; // Park
    repeat (20) @(posedge core_clk);
    chk("reset addr", 0, rom_addr);
    chk("reset strobes", 32'h0000_FFFF, strobe_n);
    chk("reset adv", 1, adv);
    resetn <= 1'b1;
    apb(1'b0, `MCSD_REG_CTRL, 0);
    chk("ctrl reset", `MCSD_CTRL_RESET, rd);
    apb(1'b0, 12'hFFC, 0);
    chk("unmapped err", 1, er);
    chk("unmapped data", 0, rd);
    apb(1'b1, `MCSD_REG_CTRL, 32'h0000_0003);
    apb(1'b0, `MCSD_REG_CTRL, 0);
    chk("ctrl rw", 32'h0000_0003, rd);
    apb(1'b1, `MCSD_REG_CTRL, 32'h0000_0001);
    k = 0;
    while (rom_addr !== 11'h035 && k < 2000) begin
      @(posedge core_clk);
      k++;
    end
    chk("park timeout", 0, k >= 2000);
    repeat (8) @(posedge core_clk);
    chk("path len", 11, seen.size());
    for (int i = 0; i < 11 && i < seen.size(); i++) chk("path", path[i], seen[i]);
    chk("held cycles", 1, held >= 508 && held <= 516);
    chk("alu pulses", 1, alu_cnt);
    chk("taken cycles", 2, taken_cnt);
    chk("strobe f0", 1, stb_cnt[0]);
    chk("strobe f1", 2, stb_cnt[1]);
    chk("strobe f2", 1, stb_cnt[2]);
    chk("gate seen", 1, gate_hi > 0);
    chk("gate off", 0, gate);
    chk("drive out", 32'h0000_0004, drv_out);
    chk("host out", 0, host_out);
    apb(1'b0, `MCSD_REG_IOFF, 0);
    chk("ioff", 32'h0000_0004, rd[15:0]);
    apb(1'b0, `MCSD_REG_STATUS, 0);
    chk("status addr", 32'h0000_0035, rd[10:0]);
    // Second program: buffer fill and drain, upper bank, write status, double density
    i_rom.mem[11'h000] = 16'h2780; // Capture serial bit
    i_rom.mem[11'h001] = 16'h2980; // Store bit
    i_rom.mem[11'h002] = 16'h2980; // Store bit
    i_rom.mem[11'h003] = 16'h2A80; // Switch buffer to drain
    i_rom.mem[11'h004] = 16'h2980; // Drain bit
    i_rom.mem[11'h005] = 16'h2980; // Drain bit
    i_rom.mem[11'h006] = 16'h4B10; // Branch on captured bit high
    i_rom.mem[11'h010] = 16'h6120; // Branch on upper bank condition high
    i_rom.mem[11'h020] = 16'h4D30; // Branch on write in progress
    i_rom.mem[11'h030] = 16'h7D40; // Double-density branch, untaken
    i_rom.mem[11'h043] = 16'h0043; // Park
    wip_n <= 1'b0;
    apb(1'b1, `MCSD_REG_CTRL, 32'h0000_0007);
    k = 0;
    while (rom_addr !== 11'h043 && k < 200) begin
      @(posedge core_clk);
      k++;
    end
    chk("second park", 0, k >= 200);
    repeat (4) @(posedge core_clk);
    chk("dd or bits", 1, or_cnt);
    chk("serial out", 1, ser_out);
    chk("taken cycles 2", 8, taken_cnt);
    chk("strobe f4", 4, stb_cnt[4]);
    chk("drive out 2", 32'h0000_0024, drv_out);
    apb(1'b0, `MCSD_REG_IOFF, 0);
    chk("ioff 2", 32'h0000_0024, rd);
    apb(1'b0, `MCSD_REG_CTRL, 0);
    chk("ctrl mask", 32'h0000_0003, rd);
    end_sim();
  end
endmodule : microcode_sequencer_decode_tb_top
